/* File: logic/htx_pkg.sv */
// Package for the transmit packet processor: offsets, fields, reset values.
// Assumes a 32-bit register bus with one aligned word per register.
package htx_pkg;
	// Register indices (printed offsets are two bytes apart; byte address = 4 x index)
	localparam logic [7:0]  HTX_IDX_CONTROL   = 8'hA0;
	localparam logic [7:0]  HTX_IDX_DATA      = 8'hA2;
	localparam logic [7:0]  HTX_IDX_STATUS    = 8'hA4;
	localparam logic [7:0]  HTX_IDX_LATCHED   = 8'hA6;
	localparam logic [7:0]  HTX_IDX_IRQ_EN    = 8'hA8;
	localparam int          HTX_ADDR_W        = 12;
	// Control fields
	localparam int          HTX_CTL_THR_LSB   = 8;
	localparam int          HTX_CTL_STOP      = 6;
	localparam int          HTX_CTL_FCS_BAD   = 5;
	localparam int          HTX_CTL_FILL      = 4;
	localparam int          HTX_CTL_MSB       = 3;
	localparam int          HTX_CTL_INV       = 2;
	localparam int          HTX_CTL_FCS_OFF   = 1;
	localparam int          HTX_CTL_FLUSH     = 0;
	localparam logic [15:0] HTX_CTL_RESET     = 16'h0800;
	localparam logic [15:0] HTX_CTL_MASK      = 16'h1F7F;
	// Latched status fields
	localparam int          HTX_LAT_OVF       = 5;
	localparam int          HTX_LAT_UNF       = 4;
	localparam int          HTX_LAT_PEND      = 3;
	localparam int          HTX_LAT_EMPTY     = 1;
	localparam int          HTX_LAT_SPACE     = 0;
	localparam logic [5:0]  HTX_IRQ_MASK      = 6'h3B;
	// Storage
	localparam int          HTX_DEPTH         = 256;
	localparam int          HTX_PTR_W         = 8;
	localparam logic [8:0]  HTX_DEPTH_CNT     = 9'h100;
	// Memory power-up time after a flush is released
	localparam int          HTX_PWRUP_NS      = 100;
	localparam int          HTX_CLK_MHZ       = 250;
	localparam int          HTX_PWRUP_CYC     = (HTX_PWRUP_NS * HTX_CLK_MHZ + 999) / 1000;
	// Framing
	localparam logic [7:0]  HTX_FLAG          = 8'h7E;
	localparam logic [15:0] HTX_CRC_POLY_REF  = 16'h8408;
	localparam logic [2:0]  HTX_ONES_LIMIT    = 3'h5;
	// Bit rate divider: one link bit per HTX_BIT_DIV clocks
	localparam logic [7:0]  HTX_BIT_DIV       = 8'h04;
	// Bus responses
	localparam logic [1:0]  HTX_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  HTX_RESP_SLVERR   = 2'h2;
	typedef enum logic [2:0] {HTX_IDLE, HTX_OPEN, HTX_DATA, HTX_FCS_LO, HTX_FCS_HI,
		HTX_CLOSE} htx_state_t;
endpackage : htx_pkg

/* File: logic/htx_core.sv */
// HDLC transmit packet processor with AXI4-Lite registers and serial bit output.
// Assumes the framer takes one bit per tx_bit_en pulse; single clock domain.
// What this block does
// - Storage available only with at least threshold x 8 + 1 free bytes.
// - Stop control halts further packets once the current packet ends.
// - Append inverted CRC normally, plain CRC when corruption control is set.
// - Corruption control has no effect while FCS is switched off.
// - Idle fill is repeated 7Eh flags, or all ones when selected.
// - Data bytes go out LSB first, or MSB first when reordering is on; FCS bytes always LSB first.
// - Inversion control flips every outgoing bit.
// - FCS appended when enabled; omitted when disabled.
// - Flush empties storage, halts transfer, powers memory down, drops writes.
// - After flush, discard data until a packet start after power-up.
// - Five registers: control, data, status, latched status, interrupt enable.
// - Byte in upper half, end flag in bit 0; data reads return zero.
// - A byte with end flag set is the last byte of its packet.
// - Storage-available bit is one when free space meets threshold.
// - Flush release sets latched empty and latched storage-available.
`timescale 1ns/1ps
module htx_core
(
	input  wire logic                           clk,       // 250 MHz clock
	input  wire logic                           rst,       // Async reset, active high
	input  wire logic [htx_pkg::HTX_ADDR_W-1:0] awaddr,    // Write address
	input  wire logic                           awvalid,   // Write address valid
	output logic                                awready,   // Write address ready
	input  wire logic [31:0]                    wdata,     // Write data
	input  wire logic [3:0]                     wstrb,     // Write byte strobes
	input  wire logic                           wvalid,    // Write data valid
	output logic                                wready,    // Write data ready
	output logic [1:0]                          bresp,     // Write response
	output logic                                bvalid,    // Write response valid
	input  wire logic                           bready,    // Write response ready
	input  wire logic [htx_pkg::HTX_ADDR_W-1:0] araddr,    // Read address
	input  wire logic                           arvalid,   // Read address valid
	output logic                                arready,   // Read address ready
	output logic [31:0]                         rdata,     // Read data
	output logic [1:0]                          rresp,     // Read response
	output logic                                rvalid,    // Read data valid
	input  wire logic                           rready,    // Read data ready
	output logic                                tx_bit,    // Serial bit toward framer
	output logic                                tx_bit_en, // One-cycle pulse: tx_bit valid
	output logic                                irq        // Level interrupt
);
	import htx_pkg::*;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [HTX_ADDR_W-1:0] aw_q, ar_q;
	logic                  aw_have_q, w_have_q, ar_have_q;
	logic [31:0]           w_q;
	logic [3:0]            ws_q;
	logic [15:0]           ctl_q;
	logic [5:0]            lat_q, ien_q;
	logic [5:0]            lat_set;

	function automatic logic [7:0] reg_idx(input logic [HTX_ADDR_W-1:0] a);
		reg_idx = a[9:2];
	endfunction : reg_idx

	wire        wr_go    = aw_have_q && w_have_q && !bvalid;
	wire [7:0]  wr_idx   = reg_idx(aw_q);
	wire        wr_ok    = (aw_q[1:0] == 2'h0) && (aw_q[HTX_ADDR_W-1:10] == '0);
	wire        wr_ctl   = wr_go && wr_ok && wr_idx == HTX_IDX_CONTROL;
	wire        wr_dat   = wr_go && wr_ok && wr_idx == HTX_IDX_DATA && ws_q[1];
	wire        wr_ien   = wr_go && wr_ok && wr_idx == HTX_IDX_IRQ_EN;
	wire        wr_map   = wr_ok && (wr_idx == HTX_IDX_CONTROL || wr_idx == HTX_IDX_DATA
		|| wr_idx == HTX_IDX_STATUS || wr_idx == HTX_IDX_LATCHED || wr_idx == HTX_IDX_IRQ_EN);
	wire        rd_go    = ar_have_q && !rvalid;
	wire [7:0]  rd_idx   = reg_idx(ar_q);
	wire        rd_ok    = (ar_q[1:0] == 2'h0) && (ar_q[HTX_ADDR_W-1:10] == '0);
	wire        rd_lat   = rd_go && rd_ok && rd_idx == HTX_IDX_LATCHED;
	wire        flush    = ctl_q[HTX_CTL_FLUSH];
	wire [15:0] ctl_wr   = ({ws_q[1], ws_q[1], ws_q[1], ws_q[1], ws_q[1], ws_q[1], ws_q[1],
		ws_q[1], {8{ws_q[0]}}} & w_q[15:0]) | (~{{8{ws_q[1]}}, {8{ws_q[0]}}} & ctl_q);
	// Next held and response state, so that the ready outputs come from flops
	wire        bvalid_d  = wr_go || (bvalid && !bready);
	wire        rvalid_d  = rd_go || (rvalid && !rready);
	wire        aw_have_d = (awvalid && awready) || (aw_have_q && !wr_go);
	wire        w_have_d  = (wvalid && wready) || (w_have_q && !wr_go);
	wire        ar_have_d = (arvalid && arready) || (ar_have_q && !rd_go);

	// Address and data capture, either order
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			aw_have_q <= 1'b0; w_have_q <= 1'b0; ar_have_q <= 1'b0;
			aw_q <= '0; ar_q <= '0; w_q <= '0; ws_q <= '0;
			awready <= 1'b1; wready <= 1'b1; arready <= 1'b1;
		end
		else
		begin
			if (awvalid && awready) begin aw_have_q <= 1'b1; aw_q <= awaddr; end
			else if (wr_go) aw_have_q <= 1'b0;
			if (wvalid && wready) begin w_have_q <= 1'b1; w_q <= wdata; ws_q <= wstrb; end
			else if (wr_go) w_have_q <= 1'b0;
			if (arvalid && arready) begin ar_have_q <= 1'b1; ar_q <= araddr; end
			else if (rd_go) ar_have_q <= 1'b0;
			awready <= !aw_have_d && !bvalid_d;
			wready  <= !w_have_d && !bvalid_d;
			arready <= !ar_have_d && !rvalid_d;
		end
	end

	// ----------------------------------------------------------------
	// Storage and status
	// ----------------------------------------------------------------
	logic [8:0]           mem [HTX_DEPTH];
	logic [HTX_PTR_W-1:0] wp_q, rp_q;
	logic [8:0]           cnt_q;
	logic                 pwr_busy_q, hunt_q, flush_q;
	logic [7:0]           pwr_cnt_q;
	logic                 rd_byte;
	logic                 space_q, empty_q;

	wire [8:0] free_cnt  = HTX_DEPTH_CNT - cnt_q;
	wire [8:0] thr_bytes = {1'b0, ctl_q[HTX_CTL_THR_LSB +: 5], 3'h0} + 9'h001;
	wire       space_now = free_cnt >= thr_bytes;
	wire       empty_now = cnt_q == 9'h000;
	wire       full_now  = cnt_q == HTX_DEPTH_CNT;
	// Writes ignored in flush; discarded during power-up and until a packet start
	wire       accept    = wr_dat && !flush && !pwr_busy_q && !hunt_q;
	wire       push      = accept && !full_now;
	wire       fl_rel    = flush_q && !flush;

	// Byte plus end flag enter storage on the upper-byte write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wp_q] <= {w_q[0], w_q[15:8]};
	end

	// Pointers, fill count, memory power-up after flush
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wp_q <= '0; rp_q <= '0; cnt_q <= '0; flush_q <= 1'b0;
			pwr_busy_q <= 1'b0; pwr_cnt_q <= '0; hunt_q <= 1'b0;
		end
		else
		begin
			flush_q <= flush;
			if (flush)
			begin
				wp_q <= '0; rp_q <= '0; cnt_q <= '0;
				pwr_busy_q <= 1'b1; pwr_cnt_q <= 8'(HTX_PWRUP_CYC); hunt_q <= 1'b1;
			end
			else
			begin
				if (pwr_busy_q)
				begin
					pwr_cnt_q <= pwr_cnt_q - 8'h01;
					if (pwr_cnt_q == 8'h01) pwr_busy_q <= 1'b0;
				end
				// This write ends a packet, so the next write starts one
				else if (hunt_q && wr_dat && w_q[0]) hunt_q <= 1'b0;
				if (push) wp_q <= wp_q + 1'b1;
				if (rd_byte) rp_q <= rp_q + 1'b1;
				cnt_q <= 9'(cnt_q + {8'h00, push} - {8'h00, rd_byte});
			end
		end
	end

	// ----------------------------------------------------------------
	// Serializer
	// ----------------------------------------------------------------
	htx_state_t st_q;
	logic [7:0]  div_q;
	logic [7:0]  sh_q;
	logic [2:0]  bit_q, ones_q;
	logic [15:0] crc_q;
	logic        last_q, stuff_q;
	logic        unf_ev, pend_ev;

	wire        bit_tick  = div_q == HTX_BIT_DIV - 8'h01;
	wire [8:0]  head      = mem[rp_q];
	wire        stuffed   = st_q inside {HTX_DATA, HTX_FCS_LO, HTX_FCS_HI};
	wire        need_zero = (stuffed || st_q == HTX_CLOSE) && ones_q == HTX_ONES_LIMIT;
	wire        cur_bit   = need_zero ? 1'b0 : sh_q[0];
	wire        crc_fb    = crc_q[0] ^ sh_q[0];
	wire        fcs_on    = !ctl_q[HTX_CTL_FCS_OFF];
	wire [15:0] crc_nxt   = {1'b0, crc_q[15:1]} ^ (crc_fb ? HTX_CRC_POLY_REF : 16'h0000);
	wire        fcs_bad   = ctl_q[HTX_CTL_FCS_BAD] && fcs_on;
	// Low byte must include the last data bit, so it comes from the next CRC
	wire [7:0]  fcs_lo    = fcs_bad ? crc_nxt[7:0] : ~crc_nxt[7:0];
	wire [7:0]  fcs_hi    = fcs_bad ? crc_q[15:8] : ~crc_q[15:8];
	wire        byte_done = bit_tick && !need_zero && bit_q == 3'h7;
	wire        can_start = !empty_now && !flush && !ctl_q[HTX_CTL_STOP];

	function automatic logic [7:0] order(input logic [7:0] b, input logic msb);
		order = msb ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
	endfunction : order

	assign rd_byte = byte_done && !flush && !empty_now
		&& (((st_q == HTX_OPEN) || (st_q == HTX_DATA && !last_q)));
	assign unf_ev  = byte_done && st_q == HTX_DATA && !last_q && empty_now && !flush;
	assign pend_ev = rd_byte && head[8];

	// Bit engine: flags, data, FCS, stuffing and CRC
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= HTX_IDLE; div_q <= '0; sh_q <= HTX_FLAG; bit_q <= '0;
			ones_q <= '0; crc_q <= 16'hFFFF; last_q <= 1'b0; tx_bit <= 1'b1;
			tx_bit_en <= 1'b0;
		end
		else
		begin
			div_q     <= bit_tick ? 8'h00 : div_q + 8'h01;
			tx_bit_en <= bit_tick;
			if (flush)
			begin
				st_q <= HTX_IDLE; sh_q <= HTX_FLAG; bit_q <= '0; ones_q <= '0;
			end
			else if (bit_tick)
			begin
				tx_bit <= cur_bit ^ ctl_q[HTX_CTL_INV];
				ones_q <= (cur_bit && stuffed) ? ones_q + 3'h1 : 3'h0;
				if (!need_zero)
				begin
					if (st_q == HTX_DATA) crc_q <= crc_nxt;
					sh_q  <= {1'b1, sh_q[7:1]};
					bit_q <= bit_q + 3'h1;
				end
				if (byte_done)
				begin
					unique case (st_q)
						HTX_IDLE, HTX_CLOSE:
						begin
							st_q <= can_start ? HTX_OPEN : HTX_IDLE;
							sh_q <= (can_start || !ctl_q[HTX_CTL_FILL]) ? HTX_FLAG : 8'hFF;
						end
						HTX_OPEN:
						begin
							st_q <= HTX_DATA; crc_q <= 16'hFFFF;
							sh_q <= order(head[7:0], ctl_q[HTX_CTL_MSB]);
							last_q <= head[8];
						end
						HTX_DATA:
							if (last_q || empty_now)
							begin
								st_q <= fcs_on ? HTX_FCS_LO : HTX_CLOSE;
								sh_q <= fcs_on ? fcs_lo : HTX_FLAG;
							end
							else
							begin
								sh_q <= order(head[7:0], ctl_q[HTX_CTL_MSB]);
								last_q <= head[8];
							end
						HTX_FCS_LO:
						begin
							st_q <= HTX_FCS_HI; sh_q <= fcs_hi;
						end
						HTX_FCS_HI:
						begin
							st_q <= HTX_CLOSE; sh_q <= HTX_FLAG;
						end
						default: st_q <= HTX_IDLE;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status, latched events, interrupt, control
	// ----------------------------------------------------------------
	assign lat_set = {wr_dat && !flush && full_now, unf_ev, pend_ev, 1'b0,
		(empty_now && !empty_q) || fl_rel, (space_now && !space_q) || fl_rel};

	// Control, enables, sticky bits (set wins over read clear)
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctl_q <= HTX_CTL_RESET; ien_q <= '0; lat_q <= '0;
			space_q <= 1'b1; empty_q <= 1'b1; irq <= 1'b0;
		end
		else
		begin
			if (wr_ctl) ctl_q <= ctl_wr & HTX_CTL_MASK;
			if (wr_ien && ws_q[0]) ien_q <= w_q[5:0] & HTX_IRQ_MASK;
			lat_q   <= ((rd_lat ? 6'h00 : lat_q) | lat_set) & HTX_IRQ_MASK;
			space_q <= space_now;
			empty_q <= empty_now;
			irq     <= |(lat_q & ien_q);
		end
	end

	wire [15:0] status_w  = {2'h0, free_cnt[8:3] > 6'd32 ? 6'd32 : free_cnt[8:3], 5'h0,
		full_now, empty_now, space_now};
	wire [15:0] rd_mux    = !rd_ok ? 16'h0000 :
		rd_idx == HTX_IDX_CONTROL ? ctl_q :
		rd_idx == HTX_IDX_STATUS  ? status_w :
		rd_idx == HTX_IDX_LATCHED ? {10'h000, lat_q} :
		rd_idx == HTX_IDX_IRQ_EN  ? {10'h000, ien_q} : 16'h0000;
	wire        rd_map    = rd_ok && (rd_idx == HTX_IDX_CONTROL || rd_idx == HTX_IDX_DATA
		|| rd_idx == HTX_IDX_STATUS || rd_idx == HTX_IDX_LATCHED || rd_idx == HTX_IDX_IRQ_EN);

	// Responses
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bvalid <= 1'b0; bresp <= HTX_RESP_OKAY;
			rvalid <= 1'b0; rresp <= HTX_RESP_OKAY; rdata <= '0;
		end
		else
		begin
			if (wr_go) begin bvalid <= 1'b1; bresp <= wr_map ? HTX_RESP_OKAY : HTX_RESP_SLVERR; end
			else if (bready) bvalid <= 1'b0;
			if (rd_go)
			begin
				rvalid <= 1'b1; rdata <= {16'h0000, rd_mux};
				rresp  <= rd_map ? HTX_RESP_OKAY : HTX_RESP_SLVERR;
			end
			else if (rready) rvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	space_thr_a: assert property (@(posedge clk) disable iff (rst)
		space_now == ({3'h0, free_cnt} >= 12'({ctl_q[12:8], 3'h0}) + 12'd1))
		else $error("space flag wrong");
	stop_hold_a: assert property (@(posedge clk) disable iff (rst)
		(st_q inside {HTX_IDLE, HTX_CLOSE} && byte_done && ctl_q[HTX_CTL_STOP])
		|=> st_q == HTX_IDLE)
		else $error("packet started while stopped");
	flush_drop_a: assert property (@(posedge clk) disable iff (rst)
		flush |=> cnt_q == 9'h000)
		else $error("flush did not empty storage");
	flush_rel_a: assert property (@(posedge clk) disable iff (rst)
		fl_rel |=> lat_q[HTX_LAT_EMPTY] && lat_q[HTX_LAT_SPACE])
		else $error("flush release not latched");
	no_fcs_a: assert property (@(posedge clk) disable iff (rst || flush)
		(st_q == HTX_DATA && byte_done && last_q && !fcs_on) |=> st_q == HTX_CLOSE)
		else $error("fcs sent while off");
	fcs_inv_a: assert property (@(posedge clk) disable iff (rst || flush)
		(st_q == HTX_DATA && byte_done && last_q && fcs_on)
		|=> sh_q == ($past(ctl_q[HTX_CTL_FCS_BAD]) ? crc_q[7:0] : ~crc_q[7:0]))
		else $error("fcs polarity");
	stuff_zero_a: assert property (@(posedge clk) disable iff (rst || flush)
		(bit_tick && need_zero) |=> tx_bit == ctl_q[HTX_CTL_INV])
		else $error("stuffed bit not zero");
	busy_drop_a: assert property (@(posedge clk) disable iff (rst)
		(pwr_busy_q || hunt_q) |-> !push)
		else $error("write taken during power-up");
	irq_lvl_a: assert property (@(posedge clk) disable iff (rst)
		|(lat_q & ien_q) |=> irq)
		else $error("irq not raised");
	pkt_c:   cover property (@(posedge clk) disable iff (rst) st_q == HTX_FCS_HI && byte_done);
	stuff_c: cover property (@(posedge clk) disable iff (rst) bit_tick && need_zero);
	rel_c:   cover property (@(posedge clk) disable iff (rst) fl_rel);
endmodule : htx_core

/* File: test/htx_link_sink.sv */
// Link-side sink: recovers HDLC frames from the serial bit stream.
// Assumes one bit per bit_en pulse, sampled on the block clock.
`timescale 1ns/1ps
module htx_link_sink (
	input  wire logic        clk,      // Block clock
	input  wire logic        rst,      // Async reset, active high
	input  wire logic        bit_in,   // Serial bit from the block
	input  wire logic        bit_en,   // Bit strobe
	input  wire logic        inv,      // Undo line inversion
	output logic [15:0]      n_frames, // Frames closed so far
	output logic [7:0]       frm_len,  // Bytes in last frame, FF if ragged
	output logic [15:0][7:0] frm_data, // Bytes of last frame
	output logic [15:0]      ones_run  // Current run of ones
);
	logic q[$];
	logic b;
	// ------------------------------------------------------------
	// Destuffing, abort and flag detection
	// ------------------------------------------------------------
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q.delete();
			n_frames <= 16'h0000;
			frm_len  <= 8'h00;
			frm_data <= '0;
			ones_run <= 16'h0000;
		end
		else if (bit_en)
		begin
			b = bit_in ^ inv;
			ones_run <= b ? ones_run + 16'h0001 : 16'h0000;
			// Zero after five ones is stuffing and dropped
			if (b || ones_run < 16'h0005)
				q.push_back(b);
			if (b && ones_run >= 16'h0006)
				q.delete();
			// Closing flag: strip its seven leading bits
			if (!b && ones_run == 16'h0006 && q.size() >= 15)
			begin
				q = q[0:q.size()-8];
				frm_len <= (q.size() % 8 == 0) ? 8'(q.size() / 8) : 8'hFF;
				for (int i = 0; i < 128; i++)
					if (i < q.size())
						frm_data[i / 8][i % 8] <= q[i];
				n_frames <= n_frames + 16'h0001;
			end
			if (!b && ones_run == 16'h0006)
				q.delete();
		end
	end
endmodule : htx_link_sink

/* File: test/tb_hdlc_transmit_packet_processor.sv */
// Testbench: registers, flush, framing options, stop control, interrupt.
// Assumes htx_pkg, htx_core and htx_link_sink are compiled first.
`timescale 1ns/1ps
module tb_hdlc_transmit_packet_processor;
	import htx_pkg::*;
	localparam logic [11:0] A_CTL = {2'b00, HTX_IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_DAT = {2'b00, HTX_IDX_DATA, 2'b00};
	localparam logic [11:0] A_STA = {2'b00, HTX_IDX_STATUS, 2'b00};
	localparam logic [11:0] A_LAT = {2'b00, HTX_IDX_LATCHED, 2'b00};
	localparam logic [11:0] A_IEN = {2'b00, HTX_IDX_IRQ_EN, 2'b00};
	localparam logic [11:0] A_BAD = 12'h2A8;
	typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [1:0] r;} htx_row_t;
	typedef struct {logic [15:0] c; int f; logic [15:0] res; logic rv; logic iv; logic on;} htx_cfg_t;
	logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, tx_bit, tx_bit_en, irq, s_inv;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [15:0] n_frames, ones_run;
	logic [7:0] frm_len;
	logic [15:0][7:0] frm_data;
	int bad_count = 0;
	int n_compared = 0;
	logic [7:0] pk [8] = '{8'hFF, 8'h7E, 8'h3C, 8'h81, 8'h00, 8'h5A, 8'hC3, 8'h01};
	htx_row_t rows [10] = '{
		'{1'b0, A_CTL, 32'h0800, HTX_RESP_OKAY},
		'{1'b0, A_IEN, 32'h0000, HTX_RESP_OKAY},
		'{1'b0, A_DAT, 32'h0000, HTX_RESP_OKAY},
		'{1'b0, A_BAD, 32'h0000, HTX_RESP_SLVERR},
		'{1'b1, A_BAD, 32'h0001, HTX_RESP_SLVERR},
		'{1'b0, A_STA, 32'h2003, HTX_RESP_OKAY},
		'{1'b1, A_CTL, 32'h1F00, HTX_RESP_OKAY},
		'{1'b0, A_CTL, 32'h1F00, HTX_RESP_OKAY},
		'{1'b1, A_IEN, 32'h003B, HTX_RESP_OKAY},
		'{1'b0, A_IEN, 32'h003B, HTX_RESP_OKAY}};
	htx_cfg_t cfg [7] = '{
		'{16'h0800, 2, 16'hF0B8, 1'b0, 1'b0, 1'b0},
		'{16'h0820, 2, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h0802, 0, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h0822, 0, 16'h0000, 1'b0, 1'b0, 1'b0},
		'{16'h0804, 2, 16'hF0B8, 1'b0, 1'b1, 1'b0},
		'{16'h0808, 2, 16'hF0B8, 1'b1, 1'b0, 1'b0},
		'{16'h0810, 2, 16'hF0B8, 1'b0, 1'b0, 1'b1}};

	htx_core htx_core_i (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .tx_bit, .tx_bit_en, .irq);
	htx_link_sink htx_link_sink_i (.clk, .rst, .bit_in(tx_bit), .bit_en(tx_bit_en),
		.inv(s_inv), .n_frames, .frm_len, .frm_data, .ones_run);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic end_sim();
		if (bad_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	task automatic tmo(input int n, input int lim);
		if (n >= lim)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			end_sim();
		end
	endtask : tmo

	task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid && n < 100);
		tmo(n, 100);
		r = bresp;
	endtask : bus_wr

	task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid && n < 100);
		tmo(n, 100);
		d = rdata;
		r = rresp;
	endtask : bus_rd

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		bus_wr(a, d, r);
		chk(32'(r), 32'(HTX_RESP_OKAY));
	endtask : wr

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		bus_rd(a, d, r);
		chk(d, e);
	endtask : rd_chk

	task automatic put(input logic [7:0] b, input logic last);
		wr(A_DAT, {16'h0000, b, 7'h00, last});
	endtask : put

	task automatic irq_is(input logic v);
		repeat (3) @(posedge clk);
		chk(32'(irq), 32'(v));
	endtask : irq_is

	task automatic wait_fr(input logic [15:0] nf);
		int n;
		n = 0;
		while (n_frames === nf && n < 3000)
		begin
			@(posedge clk);
			n++;
		end
		tmo(n, 3000);
	endtask : wait_fr

	function automatic logic [7:0] rev8(input logic [7:0] x);
		for (int i = 0; i < 8; i++)
			rev8[i] = x[7 - i];
	endfunction : rev8

	// Reflected CRC-16 over received bytes, preset all ones
	function automatic logic [15:0] crc(input int n);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < n; i++)
			for (int k = 0; k < 8; k++)
				c = (c[0] ^ frm_data[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction : crc

	task automatic chk_fr(input int n, input int f, input logic [15:0] res, input logic rv);
		chk(32'(frm_len), 32'(n + f));
		for (int i = 0; i < n; i++)
			chk(32'(frm_data[i]), 32'(rv ? rev8(pk[i]) : pk[i]));
		if (f == 2)
			chk(32'(crc(n + 2)), 32'(res));
	endtask : chk_fr

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		logic [15:0] nf;
		rst = 1'b1;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, arvalid, s_inv} = '0;
		wstrb = 4'hF;
		bready = 1'b1;
		rready = 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].wr)
				bus_wr(rows[i].a, rows[i].d, r);
			else
				bus_rd(rows[i].a, d, r);
			if (!rows[i].wr)
				chk(d, rows[i].d);
			chk(32'(r), 32'(rows[i].r));
		end
		// Flush, release, power-up discard
		wr(A_CTL, 32'h0801);
		put(8'hA5, 1'b1);
		bus_rd(A_LAT, d, r);
		rd_chk(A_LAT, 32'h0000);
		irq_is(1'b0);
		wr(A_CTL, 32'h0800);
		irq_is(1'b1);
		rd_chk(A_LAT, 32'h0003);
		rd_chk(A_STA, 32'h2003);
		irq_is(1'b0);
		put(8'h11, 1'b0);
		repeat (30) @(posedge clk);
		put(8'h22, 1'b0);
		put(8'h33, 1'b1);
		rd_chk(A_STA, 32'h2003);
		// Framing options
		foreach (cfg[j])
		begin
			wr(A_CTL, 32'(cfg[j].c));
			s_inv <= cfg[j].iv;
			repeat (200) @(posedge clk);
			nf = n_frames;
			for (int i = 0; i < 4; i++)
				put(pk[i], i == 3);
			wait_fr(nf);
			chk_fr(4, cfg[j].f, cfg[j].res, cfg[j].rv);
			repeat (100) @(posedge clk);
			chk(32'(ones_run > 16'd20), 32'(cfg[j].on));
		end
		// Stop control and threshold boundary
		bus_rd(A_LAT, d, r);
		wr(A_CTL, 32'h1F40);
		for (int i = 0; i < 7; i++)
			put(pk[i], 1'b0);
		rd_chk(A_STA, 32'h1F01);
		put(pk[7], 1'b1);
		rd_chk(A_STA, 32'h1F00);
		nf = n_frames;
		repeat (1500) @(posedge clk);
		chk(32'(n_frames), 32'(nf));
		wr(A_CTL, 32'h0800);
		wait_fr(nf);
		chk_fr(8, 2, 16'hF0B8, 1'b0);
		// Interrupt masked, unmasked, cleared
		wr(A_IEN, 32'h0000);
		irq_is(1'b0);
		wr(A_IEN, 32'h003B);
		irq_is(1'b1);
		bus_rd(A_LAT, d, r);
		chk(d & 32'h8, 32'h8);
		irq_is(1'b0);
		// Mid-run reset puts outputs and registers back to their reset state
		wr(A_CTL, 32'h0A5C);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk(32'({tx_bit, tx_bit_en, irq, bvalid, rvalid}), 32'h10);
		rst <= 1'b0;
		rd_chk(A_CTL, 32'h0800);
		rd_chk(A_IEN, 32'h0000);
		end_sim();
	end
endmodule : tb_hdlc_transmit_packet_processor
